/* rtl/fde_params.svh */
// Register offsets, field positions and reset values of the descriptor
`ifndef FDE_PARAMS_SVH
`define FDE_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define FDE_OFS_CTRL     8'h00
`define FDE_OFS_SRC      8'h04
`define FDE_OFS_DST      8'h08
`define FDE_OFS_STAT     8'h0c
`define FDE_OFS_IRQ_STAT 8'h10
`define FDE_OFS_IRQ_CLR  8'h14
`define FDE_OFS_IRQ_EN   8'h18

// ----------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------
`define FDE_BIT_NW      22
`define FDE_BIT_ERR_EN  21
`define FDE_BIT_DONE_EN 20
`define FDE_BIT_HOLD    19
`define FDE_BIT_ABORT   18
`define FDE_BIT_DIR     17
`define FDE_BIT_ARMED   16

// ----------------------------------------------------------------
// Interrupt status positions
// ----------------------------------------------------------------
`define FDE_IRQ_DONE 0
`define FDE_IRQ_ERR  1

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define FDE_COUNT_RST  16'h0000
`define FDE_ADDR_RST   32'h0000_0000
`define FDE_IRQ_RST    2'h0
`define FDE_WORDS_RST  15'h0000
`define FDE_FULL_WORDS 15'h4000
`define FDE_ADDR_STEP  32'h0000_0004

`endif

/* rtl/fde_pkg.sv */
// Types shared by the descriptor control and its word mover
package fde_pkg;

    typedef logic [31:0] fde_word_t;

    typedef enum logic [0:0] {
        FDE_IDLE = 1'b0,
        FDE_MOVE = 1'b1
    } fde_state_t;

endpackage : fde_pkg

/* rtl/fde_word_mover.sv */
// Word sequencer: counts words and drives the request toward the partner
`timescale 1ns/100ps
`include "fde_params.svh"

module fde_word_mover (
    // Clock and reset
    input  wire logic        core_clk_in,
    input  wire logic        srst_in,
    // Control from descriptor
    input  wire logic        start_in,
    input  wire logic [14:0] words_in,
    input  wire logic        hold_in,
    input  wire logic        abort_in,
    // Partner handshake
    input  wire logic        ack_in,
    input  wire logic        err_in,
    // Results
    output logic             req_out,
    output logic             done_out,
    output logic             fail_out,
    output logic [14:0]      left_out
);
    import fde_pkg::*;

    fde_state_t  state;
    fde_state_t  next_state;
    logic [14:0] left;
    logic [14:0] next_left;
    logic        next_req;
    logic        next_done;
    logic        next_fail;

    always_comb begin
        next_state = state;
        next_left  = left;
        next_done  = 1'b0;
        next_fail  = 1'b0;
        case (state)
            FDE_IDLE: begin
                if (start_in) begin
                    next_left = words_in;
                    // Under a word of count: nothing to move
                    if (words_in == `FDE_WORDS_RST) begin
                        next_done = 1'b1;
                    end else begin
                        next_state = FDE_MOVE;
                    end
                end
            end
            FDE_MOVE: begin
                if (req_out && err_in) begin
                    next_state = FDE_IDLE;
                    next_fail  = 1'b1;
                end else if (req_out && ack_in) begin
                    next_left = left - 15'h0001;
                    if (left == 15'h0001) begin
                        next_state = FDE_IDLE;
                        next_done  = 1'b1;
                    end
                end
            end
            default: begin
                next_state = FDE_IDLE;
            end
        endcase
        if (abort_in) begin
            next_state = FDE_IDLE;
            next_left  = `FDE_WORDS_RST;
            next_done  = 1'b0;
            next_fail  = 1'b0;
        end
        // Held descriptor issues idle cycles only
        next_req = (next_state == FDE_MOVE) && !hold_in;
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            state    <= FDE_IDLE;
            left     <= `FDE_WORDS_RST;
            req_out  <= 1'b0;
            done_out <= 1'b0;
            fail_out <= 1'b0;
        end else begin
            state    <= next_state;
            left     <= next_left;
            req_out  <= next_req;
            done_out <= next_done;
            fail_out <= next_fail;
        end
    end

    assign left_out = left;

    a_hold_idle: assert property (
        @(posedge core_clk_in) disable iff (srst_in)
        (hold_in && $past(hold_in)) |-> !req_out)
        else $error("request raised while descriptor held");

    a_hold_keeps: assert property (
        @(posedge core_clk_in) disable iff (srst_in)
        (state == FDE_MOVE && !req_out && !abort_in) |=> $stable(left))
        else $error("remaining count moved while idle");

endmodule : fde_word_mover

/* rtl/fde_desc_ctrl.sv */
// Descriptor control register and sequencing for one DMA descriptor slot
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`include "fde_params.svh"

module fde_desc_ctrl (
    // Clock and reset
    input  wire logic                core_clk_in,
    input  wire logic                srst_in,
    // Register port
    input  wire logic [7:0]          reg_addr_in,
    input  wire fde_pkg::fde_word_t  reg_wdata_in,
    input  wire logic                reg_wr_in,
    input  wire logic                reg_rd_in,
    output fde_pkg::fde_word_t       reg_rdata_out,
    // Word link toward the partner
    input  wire logic                xfer_ack_in,
    input  wire logic                xfer_err_in,
    output logic                     xfer_req_out,
    output logic                     xfer_dir_out,
    output fde_pkg::fde_word_t       xfer_src_addr_out,
    output fde_pkg::fde_word_t       xfer_dst_addr_out,
    // Interrupt
    output logic                     irq_out
);
    import fde_pkg::*;

    // ----------------------------------------------------------------
    // Word alignment
    // ----------------------------------------------------------------
    function automatic fde_word_t fde_align(input fde_word_t a);
        fde_align = {a[31:2], 2'b00};
    endfunction : fde_align

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic        done_en;
    logic        err_en;
    logic        nw_en;
    logic        hold;
    logic        dir;
    logic        armed;
    logic [15:0] byte_count;
    logic        next_done_en;
    logic        next_err_en;
    logic        next_nw_en;
    logic        next_hold;
    logic        next_dir;
    logic        next_armed;
    logic [15:0] next_byte_count;
    fde_word_t   src_addr;
    fde_word_t   dst_addr;
    fde_word_t   next_src_addr;
    fde_word_t   next_dst_addr;
    logic        st_done;
    logic        st_err;
    logic        st_misal;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_en;
    logic        next_st_done;
    logic        next_st_err;
    logic        next_st_misal;
    logic [1:0]  next_irq_stat;
    logic [1:0]  next_irq_en;
    logic        irq_q;
    logic        next_irq;
    fde_word_t   rd_data;
    fde_word_t   next_rd_data;

    // Decode and mover hookup
    logic        ctrl_wr;
    logic        abort_wr;
    logic        arm_wr;
    logic        step;
    logic [14:0] start_words;
    logic        mv_req;
    logic        mv_done;
    logic        mv_fail;
    logic [14:0] mv_left;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    always_comb begin
        ctrl_wr  = reg_wr_in && (reg_addr_in == `FDE_OFS_CTRL);
        abort_wr = ctrl_wr && reg_wdata_in[`FDE_BIT_ABORT];
        arm_wr   = ctrl_wr && !abort_wr && !armed
                   && reg_wdata_in[`FDE_BIT_ARMED];
        // An error beat moves no data, so addresses stay put
        step     = mv_req && xfer_ack_in && !xfer_err_in;
        if (reg_wdata_in[15:0] == `FDE_COUNT_RST) begin
            start_words = `FDE_FULL_WORDS;
        end else begin
            start_words = {1'b0, reg_wdata_in[15:2]};
        end
    end

    fde_word_mover u_mover (
        .core_clk_in (core_clk_in),
        .srst_in     (srst_in),
        .start_in    (arm_wr),
        .words_in    (start_words),
        .hold_in     (hold),
        .abort_in    (abort_wr),
        .ack_in      (xfer_ack_in),
        .err_in      (xfer_err_in),
        .req_out     (mv_req),
        .done_out    (mv_done),
        .fail_out    (mv_fail),
        .left_out    (mv_left)
    );

    // ----------------------------------------------------------------
    // Control register
    // ----------------------------------------------------------------
    always_comb begin
        next_done_en    = done_en;
        next_err_en     = err_en;
        next_nw_en      = nw_en;
        next_hold       = hold;
        next_dir        = dir;
        next_armed      = armed;
        next_byte_count = byte_count;
        if (ctrl_wr) begin
            next_done_en = reg_wdata_in[`FDE_BIT_DONE_EN];
            next_err_en  = reg_wdata_in[`FDE_BIT_ERR_EN];
            next_nw_en   = reg_wdata_in[`FDE_BIT_NW];
            next_hold    = reg_wdata_in[`FDE_BIT_HOLD];
            next_dir     = reg_wdata_in[`FDE_BIT_DIR];
            // Locked fields only take written values while disarmed
            if (!armed) begin
                next_byte_count = reg_wdata_in[15:0];
                next_armed      = reg_wdata_in[`FDE_BIT_ARMED];
            end
        end
        if (mv_done || mv_fail) begin
            next_armed = 1'b0;
        end
        if (abort_wr) begin
            next_done_en    = 1'b0;
            next_err_en     = 1'b0;
            next_nw_en      = 1'b0;
            next_hold       = 1'b0;
            next_dir        = 1'b0;
            next_armed      = 1'b0;
            next_byte_count = `FDE_COUNT_RST;
        end
    end

    // ----------------------------------------------------------------
    // Address registers
    // ----------------------------------------------------------------
    always_comb begin
        next_src_addr = src_addr;
        next_dst_addr = dst_addr;
        if (reg_wr_in && !armed) begin
            if (reg_addr_in == `FDE_OFS_SRC) begin
                next_src_addr = fde_align(reg_wdata_in);
            end else if (reg_addr_in == `FDE_OFS_DST) begin
                next_dst_addr = fde_align(reg_wdata_in);
            end
        end
        if (step) begin
            next_src_addr = src_addr + `FDE_ADDR_STEP;
            next_dst_addr = fde_align(dst_addr + `FDE_ADDR_STEP);
        end
        if (abort_wr) begin
            next_src_addr = `FDE_ADDR_RST;
            next_dst_addr = `FDE_ADDR_RST;
        end
    end

    // ----------------------------------------------------------------
    // Status and interrupts
    // ----------------------------------------------------------------
    always_comb begin
        next_st_done  = st_done;
        next_st_err   = st_err;
        next_st_misal = st_misal;
        next_irq_stat = irq_stat;
        next_irq_en   = irq_en;
        if (reg_wr_in && reg_addr_in == `FDE_OFS_IRQ_CLR) begin
            next_irq_stat = irq_stat & ~reg_wdata_in[1:0];
        end else if (reg_wr_in && reg_addr_in == `FDE_OFS_IRQ_EN) begin
            next_irq_en = reg_wdata_in[1:0];
        end
        if (arm_wr) begin
            next_st_done  = 1'b0;
            next_st_err   = 1'b0;
            next_st_misal = 1'b0;
            next_irq_stat = `FDE_IRQ_RST;
        end
        // Sets come after the IRQ_CLR and arm clears so those never lose an event; abort clears after the sets
        if (arm_wr && reg_wdata_in[1:0] != 2'h0) begin
            next_st_misal = 1'b1;
            if (reg_wdata_in[`FDE_BIT_NW]) begin
                next_irq_stat[`FDE_IRQ_ERR] = 1'b1;
            end
        end
        if (mv_done) begin
            next_st_done = 1'b1;
            if (done_en) begin
                next_irq_stat[`FDE_IRQ_DONE] = 1'b1;
            end
        end
        if (mv_fail) begin
            next_st_err = 1'b1;
            if (err_en) begin
                next_irq_stat[`FDE_IRQ_ERR] = 1'b1;
            end
        end
        if (abort_wr) begin
            next_st_done  = 1'b0;
            next_st_err   = 1'b0;
            next_st_misal = 1'b0;
            next_irq_stat = `FDE_IRQ_RST;
        end
        next_irq = |(next_irq_stat & next_irq_en);
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    always_comb begin
        next_rd_data = `FDE_ADDR_RST;
        if (reg_rd_in) begin
            if (reg_addr_in == `FDE_OFS_CTRL) begin
                // Reserved bits and the abort trigger read zero
                next_rd_data = {9'h000, nw_en, err_en, done_en, hold,
                                1'b0, dir, armed, byte_count};
            end else if (reg_addr_in == `FDE_OFS_SRC) begin
                next_rd_data = src_addr;
            end else if (reg_addr_in == `FDE_OFS_DST) begin
                next_rd_data = dst_addr;
            end else if (reg_addr_in == `FDE_OFS_STAT) begin
                next_rd_data = {1'b0, mv_left, 12'h000,
                                st_misal, st_err, st_done, armed};
            end else if (reg_addr_in == `FDE_OFS_IRQ_STAT) begin
                next_rd_data = {30'h0000_0000, irq_stat};
            end else if (reg_addr_in == `FDE_OFS_IRQ_EN) begin
                next_rd_data = {30'h0000_0000, irq_en};
            end else begin
                next_rd_data = `FDE_ADDR_RST;
            end
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            done_en    <= 1'b0;
            err_en     <= 1'b0;
            nw_en      <= 1'b0;
            hold       <= 1'b0;
            dir        <= 1'b0;
            armed      <= 1'b0;
            byte_count <= `FDE_COUNT_RST;
            src_addr   <= `FDE_ADDR_RST;
            dst_addr   <= `FDE_ADDR_RST;
            st_done    <= 1'b0;
            st_err     <= 1'b0;
            st_misal   <= 1'b0;
            irq_stat   <= `FDE_IRQ_RST;
            irq_en     <= `FDE_IRQ_RST;
            irq_q      <= 1'b0;
            rd_data    <= `FDE_ADDR_RST;
        end else begin
            done_en    <= next_done_en;
            err_en     <= next_err_en;
            nw_en      <= next_nw_en;
            hold       <= next_hold;
            dir        <= next_dir;
            armed      <= next_armed;
            byte_count <= next_byte_count;
            src_addr   <= next_src_addr;
            dst_addr   <= next_dst_addr;
            st_done    <= next_st_done;
            st_err     <= next_st_err;
            st_misal   <= next_st_misal;
            irq_stat   <= next_irq_stat;
            irq_en     <= next_irq_en;
            irq_q      <= next_irq;
            rd_data    <= next_rd_data;
        end
    end

    assign reg_rdata_out     = rd_data;
    assign xfer_req_out      = mv_req;
    assign xfer_dir_out      = dir;
    assign xfer_src_addr_out = src_addr;
    assign xfer_dst_addr_out = dst_addr;
    assign irq_out           = irq_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_abort_reads0: assert property (
        @(posedge core_clk_in) disable iff (srst_in)
        (reg_rd_in && reg_addr_in == `FDE_OFS_CTRL)
        |=> !reg_rdata_out[`FDE_BIT_ABORT] && reg_rdata_out[31:23] == 9'h0)
        else $error("abort bit or reserved bits read nonzero");

    a_dst_aligned: assert property (
        @(posedge core_clk_in) disable iff (srst_in)
        xfer_dst_addr_out[1:0] == 2'b00)
        else $error("destination address not word aligned");

    a_dst_advance: assert property (
        @(posedge core_clk_in) disable iff (srst_in)
        (step && !abort_wr)
        |=> xfer_dst_addr_out == $past(xfer_dst_addr_out) + 32'h4)
        else $error("destination did not advance by one word");

    a_count_locked: assert property (
        @(posedge core_clk_in) disable iff (srst_in)
        (armed && ctrl_wr && !abort_wr) |=> $stable(byte_count))
        else $error("byte count changed while armed");

    a_done_disarm: assert property (
        @(posedge core_clk_in) disable iff (srst_in)
        mv_done |-> ##1 !armed)
        else $error("armed flag stayed set after completion");

    a_done_gated: assert property (
        @(posedge core_clk_in) disable iff (srst_in)
        $rose(irq_stat[`FDE_IRQ_DONE]) |-> $past(done_en) && $past(mv_done))
        else $error("done interrupt without enable or completion");

    a_arm_clears: assert property (
        @(posedge core_clk_in) disable iff (srst_in)
        $rose(armed) |-> !st_done && !st_err && !irq_stat[`FDE_IRQ_DONE])
        else $error("arming left old results standing");

    a_misal_off: assert property (
        @(posedge core_clk_in) disable iff (srst_in)
        (arm_wr && reg_wdata_in[1:0] != 2'h0 && !reg_wdata_in[`FDE_BIT_NW])
        |=> !irq_stat[`FDE_IRQ_ERR] && st_misal)
        else $error("misaligned count mishandled with enable clear");

    a_zero_full: assert property (
        @(posedge core_clk_in) disable iff (srst_in)
        arm_wr |=> mv_left == (($past(reg_wdata_in[15:0]) == 16'h0)
                 ? 15'h4000 : {1'b0, $past(reg_wdata_in[15:2])}))
        else $error("word count loaded wrongly");

    a_abort_clear: assert property (
        @(posedge core_clk_in) disable iff (srst_in)
        abort_wr |=> !armed && !xfer_req_out && byte_count == 16'h0
                     && xfer_dst_addr_out == 32'h0)
        else $error("abort left descriptor state behind");

endmodule : fde_desc_ctrl

/* bench/fde_partner.sv */
// Far-side word acceptor: answers fast, slowly, or with an error
`timescale 1ns/100ps

module fde_partner (
    // Clock and reset
    input  wire logic core_clk_in,
    input  wire logic srst_in,
    // Word link
    input  wire logic req_in,
    input  wire logic slow_in,
    input  wire logic fail_in,
    output logic      ack_out,
    output logic      err_out
);
    logic [1:0] wait_cnt;

    // Acks only follow a seen request; late ones land after req drops
    always_ff @(posedge core_clk_in) begin
        if (srst_in || !req_in) begin
            ack_out  <= 1'b0;
            err_out  <= 1'b0;
            wait_cnt <= 2'h0;
        end else begin
            wait_cnt <= wait_cnt + 2'h1;
            ack_out  <= !fail_in && (!slow_in || wait_cnt == 2'h3);
            err_out  <= fail_in;
        end
    end
endmodule : fde_partner

/* bench/fde_desc_ctrl_test.sv */
// Self-checking bench for the descriptor control slot
`timescale 1ns/100ps
`include "fde_params.svh"

module fde_desc_ctrl_test;
    import fde_pkg::*;
    logic       core_clk_in, srst_in, reg_wr, reg_rd;
    logic [7:0] reg_addr;
    fde_word_t  reg_wdata, reg_rdata, src, dst, d;
    logic       ack, err, req, dir, irq, slow, fail;
    int         n_errors, samples_checked, cyc;

    fde_desc_ctrl fde_desc_ctrl_i (
        .core_clk_in(core_clk_in), .srst_in(srst_in),
        .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
        .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata),
        .xfer_ack_in(ack), .xfer_err_in(err), .xfer_req_out(req),
        .xfer_dir_out(dir), .xfer_src_addr_out(src),
        .xfer_dst_addr_out(dst), .irq_out(irq));

    fde_partner fde_partner_i (
        .core_clk_in(core_clk_in), .srst_in(srst_in), .req_in(req),
        .slow_in(slow), .fail_in(fail), .ack_out(ack), .err_out(err));

    // ------------------------------------------------------------
    // Bus access and comparison
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, got);
        samples_checked++;
        if (got !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input fde_word_t v);
        @(posedge core_clk_in);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge core_clk_in);
        reg_wr <= 1'b0;
        // Let the edge's register updates settle before any look
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge core_clk_in);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk_in);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    task automatic rdc(input logic [7:0] a, input fde_word_t e, string nm);
        rd(a);
        chk(nm, e, d);
    endtask : rdc

    // Polls armed bit; a slot still armed at the limit is a mismatch
    task automatic wait_idle;
        for (int i = 0; i < 20000; i++) begin
            rd(`FDE_OFS_CTRL);
            if (!d[16]) break;
        end
        chk("idle", 32'h0, {31'h0, d[16]});
    endtask : wait_idle

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_fields;
        rdc(`FDE_OFS_CTRL, 32'h0, "ctrl_rst");
        rdc(8'h1c, 32'h0, "unmapped");
        wr(`FDE_OFS_CTRL, 32'hfffa_0004);
        rdc(`FDE_OFS_CTRL, 32'h007a_0004, "ctrl_rb");
        chk("dir", 32'h1, {31'h0, dir});
        wr(`FDE_OFS_CTRL, 32'h0006_0004);
        rdc(`FDE_OFS_CTRL, 32'h0, "ctrl_abort");
        chk("dir_clr", 32'h0, {31'h0, dir});
    endtask : t_fields

    task automatic t_done;
        wr(`FDE_OFS_IRQ_EN, 32'h1);
        wr(`FDE_OFS_DST, 32'h0000_0100);
        wr(`FDE_OFS_SRC, 32'h0000_0200);
        wr(`FDE_OFS_CTRL, 32'h0011_0008);
        wr(`FDE_OFS_DST, 32'h0000_0500);
        wait_idle();
        chk("dst", 32'h0000_0108, dst);
        chk("src", 32'h0000_0208, src);
        rdc(`FDE_OFS_CTRL, 32'h0010_0008, "disarm");
        rdc(`FDE_OFS_IRQ_STAT, 32'h1, "done_irq");
        chk("irq", 32'h1, {31'h0, irq});
    endtask : t_done

    task automatic t_hold;
        slow = 1'b1;
        wr(`FDE_OFS_CTRL, 32'h0019_0010);
        rdc(`FDE_OFS_IRQ_STAT, 32'h0, "arm_clr");
        repeat (8) @(posedge core_clk_in);
        #1;
        chk("req_held", 32'h0, {31'h0, req});
        chk("dst_held", 32'h0000_0108, dst);
        // Resume; armed bit and count written while armed must not land
        wr(`FDE_OFS_CTRL, 32'h0010_0020);
        wait_idle();
        chk("dst_resume", 32'h0000_0118, dst);
        rdc(`FDE_OFS_CTRL, 32'h0010_0010, "lock_count");
        slow = 1'b0;
    endtask : t_hold

    task automatic t_misal;
        wr(`FDE_OFS_IRQ_CLR, 32'h3);
        chk("irq_clr", 32'h0, {31'h0, irq});
        wr(`FDE_OFS_IRQ_EN, 32'h3);
        wr(`FDE_OFS_CTRL, 32'h0041_000e);
        rdc(`FDE_OFS_IRQ_STAT, 32'h2, "nw_irq");
        chk("irq_nw", 32'h1, {31'h0, irq});
        wait_idle();
        chk("dst_words", 32'h0000_0124, dst);
        rdc(`FDE_OFS_IRQ_STAT, 32'h2, "no_done");
        // Misaligned count under one word, enable clear: no interrupt
        wr(`FDE_OFS_CTRL, 32'h0001_0003);
        rdc(`FDE_OFS_IRQ_STAT, 32'h0, "nw_off");
        wait_idle();
        rdc(`FDE_OFS_STAT, 32'h0000_000a, "short_stat");
        chk("irq_off", 32'h0, {31'h0, irq});
    endtask : t_misal

    // Partner error with the error enable clear, then set
    task automatic t_fail;
        fail = 1'b1;
        for (int en = 0; en < 2; en++) begin
            wr(`FDE_OFS_IRQ_CLR, 32'h3);
            wr(`FDE_OFS_CTRL, 32'h0001_0010 | (en << 21));
            wait_idle();
            rdc(`FDE_OFS_IRQ_STAT, en << 1, "err_irq");
        end
        fail = 1'b0;
    endtask : t_fail

    task automatic t_full;
        wr(`FDE_OFS_CTRL, 32'h0001_0000);
        repeat (20) @(posedge core_clk_in);
        #1;
        chk("req_run", 32'h1, {31'h0, req});
        wr(`FDE_OFS_CTRL, 32'h0004_0000);
        rdc(`FDE_OFS_STAT, 32'h0, "stat_abort");
        chk("req_abort", 32'h0, {31'h0, req});
        chk("dst_abort", 32'h0, dst);
        wr(`FDE_OFS_CTRL, 32'h0001_0000);
        wait_idle();
        chk("dst_full", 32'h0001_0000, dst);
    endtask : t_full

    // ------------------------------------------------------------
    // Clock, timeout and main sequence
    // ------------------------------------------------------------
    task automatic conclude;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude

    initial begin
        core_clk_in = 1'b0;
        forever #2 core_clk_in = ~core_clk_in;
    end

    // Whole run is about 17k cycles, dominated by the full-size transfer
    always @(posedge core_clk_in) begin
        cyc++;
        if (cyc == 80000) begin
            n_errors++;
            conclude();
        end
    end

    initial begin
        srst_in   = 1'b1;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 32'h0;
        slow      = 1'b0;
        fail      = 1'b0;
        repeat (8) @(posedge core_clk_in);
        srst_in <= 1'b0;
        t_fields();
        t_done();
        t_hold();
        t_misal();
        t_fail();
        t_full();
        conclude();
    end
endmodule : fde_desc_ctrl_test
